// ### rtl/tcc_pkg.sv
/*
  Shared constants and state types for the timer channel capture/compare
  and status block: register indexes, reset values, field positions and
  function encodings.
  Assumes a single 100 MHz clock and an 8-bit register port.
*/
package tcc_pkg;

  // channel count and widths
  localparam int NUM_CH = 5;
  localparam int CNT_W = 16;
  localparam int DATA_W = 8;
  localparam int FLD_W = 3;

  // register index inside a channel, low address bits
  localparam logic [1:0] REG_IOSEL = 2'h0;
  localparam logic [1:0] REG_FLAGS = 2'h1;
  localparam logic [1:0] REG_IEN = 2'h2;

  // reset values, reserved bits read as one
  localparam logic [7:0] IOSEL_RESET = 8'h88;
  localparam logic [7:0] IOSEL_RSVD = 8'h88;
  localparam logic [7:0] FLAGS_RESET = 8'hF8;
  localparam logic [7:0] FLAGS_RSVD = 8'hF8;
  localparam logic [7:0] IEN_RESET = 8'hF8;
  localparam logic [7:0] IEN_RSVD = 8'hF8;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // field positions in the io select register
  localparam int FLD_B_LSB = 4;
  localparam int FLD_A_LSB = 0;

  // flag and enable bit positions
  localparam int BIT_WRAP = 2;
  localparam int BIT_B = 1;
  localparam int BIT_A = 0;

  // function field: top bit selects capture, low bits the action
  localparam int FN_CAPTURE_BIT = 2;
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_DRIVE0 = 2'h1;
  localparam logic [1:0] OUT_DRIVE1 = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [2:0] FIELD_IGNORED = 3'h0;

  // channels with special behaviour
  localparam int CH_TOGGLE_AS_SET = 2;
  localparam int CH_PHASE = 2;
  localparam int CH_PAIR_LO = 3;
  localparam int CH_PAIR_HI = 4;
  localparam int NUM_DMA_CH = 4;

  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_MIN = 16'h0000;

  // state of one general register pin unit
  typedef struct packed {
    logic pin_prev;
    logic eq_prev;
    logic pin_out;
  } tcc_unit_s;

  // state of the register block
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] iosel;
    logic [NUM_CH-1:0][7:0] flags;
    logic [NUM_CH-1:0][7:0] ien;
    logic [NUM_CH-1:0][2:0] armed;
    logic [7:0] rdata;
  } tcc_top_s;

endpackage

// ### rtl/tcc_gr_if.sv
/*
  Carrier between the register block and one general register unit:
  function field and values in, events and pin drive out.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface tcc_gr_if;
  logic [2:0] field;
  logic [15:0] count;
  logic [15:0] compare;
  logic pin_in;
  logic toggle_sets;
  logic event_hit;
  logic capture;
  logic pin_out;
  logic pin_oe;

  modport unit (
    input field,
    input count,
    input compare,
    input pin_in,
    input toggle_sets,
    output event_hit,
    output capture,
    output pin_out,
    output pin_oe
  );

  modport owner (
    output field,
    output count,
    output compare,
    output pin_in,
    output toggle_sets,
    input event_hit,
    input capture,
    input pin_out,
    input pin_oe
  );
endinterface

// ### rtl/tcc_gr_unit.sv
/*
  One general register pin unit: compare match or input capture detection
  and the compare output level of its channel pin.
  Assumes pin input and counter are synchronous to clk.
*/
`timescale 1ns/1ps
module tcc_gr_unit (
  input wire logic clk,
  input wire logic rstn,
  tcc_gr_if.unit gr
);

  tcc_pkg::tcc_unit_s st;
  tcc_pkg::tcc_unit_s next_st;
  logic cap_mode;
  logic [1:0] act;
  logic eq;
  logic match;
  logic rise;
  logic fall;

  // decode the field and detect the events
  assign cap_mode = gr.field[tcc_pkg::FN_CAPTURE_BIT];
  assign act = gr.field[1:0];
  assign eq = (gr.count == gr.compare);
  assign match = eq & ~st.eq_prev & ~cap_mode;
  assign rise = gr.pin_in & ~st.pin_prev;
  assign fall = ~gr.pin_in & st.pin_prev;

  // capture edge choice, both codes with the high action bit set take both edges
  always_comb begin
    unique case (act)
      tcc_pkg::CAP_RISE: gr.capture = cap_mode & rise;
      tcc_pkg::CAP_FALL: gr.capture = cap_mode & fall;
      default: gr.capture = cap_mode & (rise | fall);
    endcase
  end

  assign gr.event_hit = match | gr.capture;
  assign gr.pin_out = st.pin_out;
  assign gr.pin_oe = ~cap_mode & (act != tcc_pkg::OUT_NONE);

  // next pin level on a compare match
  always_comb begin
    next_st = st;
    next_st.pin_prev = gr.pin_in;
    next_st.eq_prev = eq;
    if (match) begin
      unique case (act)
        tcc_pkg::OUT_NONE: next_st.pin_out = st.pin_out;
        tcc_pkg::OUT_DRIVE0: next_st.pin_out = 1'b0;
        tcc_pkg::OUT_DRIVE1: next_st.pin_out = 1'b1;
        tcc_pkg::OUT_TOGGLE: begin
          next_st.pin_out = gr.toggle_sets | ~st.pin_out;
        end
      endcase
    end
  end

  // pin output is low from reset until the first match
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // tcc_gr_unit

// ### rtl/tcc_top.sv
/*
  Capture/compare io selection and status flags for five 16-bit timer
  channels, with the per-channel interrupt enables, on an 8-bit register
  port. Counters and general registers live outside; this block sees
  their values and tells the outside when to capture.
  Assumes all inputs synchronous to CLK, single-cycle read and write
  strobes, and counter tick pulses from the counter logic.
*/
`timescale 1ns/1ps
module tcc_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic STANDBY,
  input wire logic [4:0] CPU_ADDR,
  input wire logic CPU_WE,
  input wire logic CPU_RE,
  input wire logic [7:0] CPU_WDATA,
  output logic [7:0] CPU_RDATA,
  input wire logic [4:0][15:0] CHANNEL_COUNTER,
  input wire logic [4:0][15:0] GENERAL_REG_A,
  input wire logic [4:0][15:0] GENERAL_REG_B,
  input wire logic [4:0] COUNT_UP_TICK,
  input wire logic [4:0] COUNT_DOWN_TICK,
  input wire logic PHASE_COUNT_SELECT,
  input wire logic COMBO_MODE_HI,
  input wire logic COMBO_MODE_LO,
  input wire logic [3:0] DMA_START_A,
  input wire logic [4:0] CHANNEL_PIN_A_IN,
  output logic [4:0] CHANNEL_PIN_A_OUT,
  output logic [4:0] CHANNEL_PIN_A_OE,
  input wire logic [4:0] CHANNEL_PIN_B_IN,
  output logic [4:0] CHANNEL_PIN_B_OUT,
  output logic [4:0] CHANNEL_PIN_B_OE,
  output logic [4:0] CAPTURE_A,
  output logic [4:0] CAPTURE_B,
  output logic [4:0] WRAP_IRQ,
  output logic [4:0] MATCH_CAPTURE_IRQ_A,
  output logic [4:0] MATCH_CAPTURE_IRQ_B
);

  tcc_pkg::tcc_top_s st;
  tcc_pkg::tcc_top_s next_st;
  logic [2:0] acc_ch;
  logic [1:0] acc_reg;
  logic acc_hit;
  logic [4:0] ev_a;
  logic [4:0] ev_b;
  logic [4:0] ev_wrap;
  logic [4:0] updown_ok;
  logic pwm3;

  // flag update: hardware set wins over any clear
  function automatic logic [2:0] flag_next(
    input logic [2:0] cur,
    input logic [2:0] set,
    input logic [2:0] clr
  );
    flag_next = set | (cur & ~clr);
  endfunction

  // read view of a register with reserved bits forced high
  function automatic logic [7:0] with_rsvd(
    input logic [7:0] val,
    input logic [7:0] rsvd
  );
    with_rsvd = val | rsvd;
  endfunction

  // address split: channel in high bits, register in low bits
  assign acc_ch = CPU_ADDR[4:2];
  assign acc_reg = CPU_ADDR[1:0];
  assign acc_hit = (acc_ch < 3'(tcc_pkg::NUM_CH)) &&
                   (acc_reg != 2'h3);

  // complementary or reset-synchronized three-phase PWM
  assign pwm3 = COMBO_MODE_HI;

  // up/down counting allowed per channel
  always_comb begin
    updown_ok = '0;
    updown_ok[tcc_pkg::CH_PHASE] = PHASE_COUNT_SELECT;
    updown_ok[tcc_pkg::CH_PAIR_LO] = COMBO_MODE_HI & ~COMBO_MODE_LO;
    updown_ok[tcc_pkg::CH_PAIR_HI] = COMBO_MODE_HI & ~COMBO_MODE_LO;
  end

  // wrap events from counter ticks at the ends of range
  always_comb begin
    for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
      ev_wrap[ch] = (COUNT_UP_TICK[ch] &&
                     CHANNEL_COUNTER[ch] == tcc_pkg::CNT_MAX) ||
                    (COUNT_DOWN_TICK[ch] && updown_ok[ch] &&
                     CHANNEL_COUNTER[ch] == tcc_pkg::CNT_MIN);
    end
  end

  // one unit per general register, both per channel
  for (genvar g = 0; g < tcc_pkg::NUM_CH; g++) begin : g_ch
    tcc_gr_if ifa ();
    tcc_gr_if ifb ();
    logic ignore;

    // pair channels drop their selection under three-phase PWM
    assign ignore = pwm3 && (g == tcc_pkg::CH_PAIR_LO ||
                             g == tcc_pkg::CH_PAIR_HI);

    // register A side
    assign ifa.field = ignore ? tcc_pkg::FIELD_IGNORED :
      st.iosel[g][tcc_pkg::FLD_A_LSB +: tcc_pkg::FLD_W];
    assign ifa.count = CHANNEL_COUNTER[g];
    assign ifa.compare = GENERAL_REG_A[g];
    assign ifa.pin_in = CHANNEL_PIN_A_IN[g];
    assign ifa.toggle_sets = (g == tcc_pkg::CH_TOGGLE_AS_SET);

    // register B side
    assign ifb.field = ignore ? tcc_pkg::FIELD_IGNORED :
      st.iosel[g][tcc_pkg::FLD_B_LSB +: tcc_pkg::FLD_W];
    assign ifb.count = CHANNEL_COUNTER[g];
    assign ifb.compare = GENERAL_REG_B[g];
    assign ifb.pin_in = CHANNEL_PIN_B_IN[g];
    assign ifb.toggle_sets = (g == tcc_pkg::CH_TOGGLE_AS_SET);

    tcc_gr_unit u_a (
      .clk(CLK),
      .rstn(RSTN),
      .gr(ifa.unit)
    );

    tcc_gr_unit u_b (
      .clk(CLK),
      .rstn(RSTN),
      .gr(ifb.unit)
    );

    // results back to channel level
    assign ev_a[g] = ifa.event_hit;
    assign ev_b[g] = ifb.event_hit;
    assign CAPTURE_A[g] = ifa.capture;
    assign CAPTURE_B[g] = ifb.capture;
    assign CHANNEL_PIN_A_OUT[g] = ifa.pin_out;
    assign CHANNEL_PIN_A_OE[g] = ifa.pin_oe;
    assign CHANNEL_PIN_B_OUT[g] = ifb.pin_out;
    assign CHANNEL_PIN_B_OE[g] = ifb.pin_oe;
  end

  // register update, flag handshake and read data
  always_comb begin
    logic [2:0] cur;
    logic [2:0] set;
    logic [2:0] clr;
    logic sel;
    cur = '0;
    set = '0;
    clr = '0;
    sel = 1'b0;
    next_st = st;
    for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
      sel = acc_hit && (acc_ch == 3'(ch));
      cur = st.flags[ch][2:0];
      set = '0;
      set[tcc_pkg::BIT_WRAP] = ev_wrap[ch];
      set[tcc_pkg::BIT_B] = ev_b[ch];
      set[tcc_pkg::BIT_A] = ev_a[ch];
      clr = '0;
      // write of zero clears only a bit read at one before
      if (CPU_WE && sel && acc_reg == tcc_pkg::REG_FLAGS) begin
        clr = st.armed[ch] & ~CPU_WDATA[2:0];
      end
      // DMA start takes flag A down on the low channels
      if (ch < tcc_pkg::NUM_DMA_CH) begin
        if (DMA_START_A[ch]) begin
          clr[tcc_pkg::BIT_A] = 1'b1;
        end
      end
      next_st.flags[ch] = with_rsvd({5'h00, flag_next(cur, set, clr)},
                                    tcc_pkg::FLAGS_RSVD);
      // arm on a read that sees one, disarm on write or once clear
      if (CPU_RE && sel && acc_reg == tcc_pkg::REG_FLAGS) begin
        next_st.armed[ch] = (st.armed[ch] | cur) &
                            next_st.flags[ch][2:0];
      end else if (CPU_WE && sel && acc_reg == tcc_pkg::REG_FLAGS) begin
        next_st.armed[ch] = '0;
      end else begin
        next_st.armed[ch] = st.armed[ch] & next_st.flags[ch][2:0];
      end
      // control registers, reserved bits held at one
      if (CPU_WE && sel && acc_reg == tcc_pkg::REG_IOSEL) begin
        next_st.iosel[ch] = with_rsvd(CPU_WDATA,
                                      tcc_pkg::IOSEL_RSVD);
      end
      if (CPU_WE && sel && acc_reg == tcc_pkg::REG_IEN) begin
        next_st.ien[ch] = with_rsvd(CPU_WDATA, tcc_pkg::IEN_RSVD);
      end
    end
    // read data of the addressed register, next cycle
    if (CPU_RE) begin
      if (!acc_hit) begin
        next_st.rdata = tcc_pkg::UNMAPPED_RDATA;
      end else begin
        unique case (acc_reg)
          tcc_pkg::REG_IOSEL: next_st.rdata = st.iosel[acc_ch];
          tcc_pkg::REG_FLAGS: next_st.rdata = st.flags[acc_ch];
          default: next_st.rdata = st.ien[acc_ch];
        endcase
      end
    end
    // standby puts every channel register back to its initial value; read data and unit pin levels are kept
    if (STANDBY) begin
      for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
        next_st.iosel[ch] = tcc_pkg::IOSEL_RESET;
        next_st.flags[ch] = tcc_pkg::FLAGS_RESET;
        next_st.ien[ch] = tcc_pkg::IEN_RESET;
        next_st.armed[ch] = '0;
      end
    end
  end

  // state register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
        st.iosel[ch] <= tcc_pkg::IOSEL_RESET;
        st.flags[ch] <= tcc_pkg::FLAGS_RESET;
        st.ien[ch] <= tcc_pkg::IEN_RESET;
        st.armed[ch] <= '0;
      end
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign CPU_RDATA = st.rdata;

  // interrupt requests gated by the enable at the same bit
  always_comb begin
    for (int ch = 0; ch < tcc_pkg::NUM_CH; ch++) begin
      WRAP_IRQ[ch] = st.flags[ch][tcc_pkg::BIT_WRAP] &
                     st.ien[ch][tcc_pkg::BIT_WRAP];
      MATCH_CAPTURE_IRQ_B[ch] = st.flags[ch][tcc_pkg::BIT_B] &
                                st.ien[ch][tcc_pkg::BIT_B];
      MATCH_CAPTURE_IRQ_A[ch] = st.flags[ch][tcc_pkg::BIT_A] &
                                st.ien[ch][tcc_pkg::BIT_A];
    end
  end

endmodule // tcc_top

// ### test/tcc_asserts.sv
/*
  Port checker for tcc_top: register reads, event causes, pin levels.
  Assumes one clock, CLK, and the asynchronous active-low RSTN.
*/
`timescale 1ns/1ps
module tcc_asserts (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [4:0] CPU_ADDR,
  input wire logic CPU_WE,
  input wire logic CPU_RE,
  input wire logic [7:0] CPU_RDATA,
  input wire logic [4:0][15:0] CHANNEL_COUNTER,
  input wire logic [4:0][15:0] GENERAL_REG_A,
  input wire logic [4:0] COUNT_UP_TICK,
  input wire logic COMBO_MODE_HI,
  input wire logic [4:0] CHANNEL_PIN_A_IN,
  input wire logic [4:0] CHANNEL_PIN_B_IN,
  input wire logic [4:0] CHANNEL_PIN_A_OUT,
  input wire logic [4:0] CHANNEL_PIN_A_OE,
  input wire logic [4:0] CAPTURE_A,
  input wire logic [4:0] CAPTURE_B,
  input wire logic [4:0] WRAP_IRQ,
  input wire logic [4:0] MATCH_CAPTURE_IRQ_A
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // a read of a mapped register of the given kind one cycle back
  sequence s_rd(r);
    $past(CPU_RE) && $past(CPU_ADDR[1:0]) == r && $past(CPU_ADDR[4:2]) < 3'h5;
  endsequence
  // three-phase mode held for two cycles
  sequence s_combo;
    COMBO_MODE_HI ##1 COMBO_MODE_HI;
  endsequence

  chk_iosel_rsvd: assert property (
    s_rd(2'h0) |-> CPU_RDATA[7] && CPU_RDATA[3])
    else $error("io select reserved bit read as zero");
  chk_flag_rsvd: assert property (
    s_rd(2'h1) |-> CPU_RDATA[7:3] == 5'h1F)
    else $error("flag reserved bits not all one");
  chk_unmapped_zero: assert property (
    $past(CPU_RE) && ($past(CPU_ADDR[4:2]) > 3'h4 ||
    $past(CPU_ADDR[1:0]) == 2'h3) |-> CPU_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_cap_edge: assert property (
    (CAPTURE_B & ~(CHANNEL_PIN_B_IN ^ $past(CHANNEL_PIN_B_IN))) == 5'h00)
    else $error("capture pulse without pin edge");
  chk_cap_a_edge: assert property (
    (CAPTURE_A & ~(CHANNEL_PIN_A_IN ^ $past(CHANNEL_PIN_A_IN))) == 5'h00)
    else $error("capture a pulse without pin edge");
  chk_pin_cause: assert property (
    $changed(CHANNEL_PIN_A_OUT[0]) |->
    $past(CHANNEL_COUNTER[0] == GENERAL_REG_A[0]))
    else $error("pin moved without compare match");
  chk_irq_a_cause: assert property (
    $rose(MATCH_CAPTURE_IRQ_A[0]) |-> $past(CPU_WE || CAPTURE_A[0] ||
    CHANNEL_COUNTER[0] == GENERAL_REG_A[0]))
    else $error("irq a rose without cause");
  chk_wrap_cause: assert property (
    $rose(WRAP_IRQ[0]) |-> $past(CPU_WE || COUNT_UP_TICK[0] &&
    CHANNEL_COUNTER[0] == 16'hFFFF))
    else $error("wrap irq rose without overflow");
  chk_combo_off: assert property (
    s_combo |-> CHANNEL_PIN_A_OE[4:3] == 2'h0)
    else $error("pin drive in three-phase mode");
  chk_reset_pin: assert property (
    $rose(RSTN) |-> CHANNEL_PIN_A_OUT == 5'h00)
    else $error("pin high after reset");
endmodule // tcc_asserts

bind tcc_top tcc_asserts chk_u (.*);

// ### test/tcc_pin_model.sv
/*
  Far-side pin model: toggles the capture inputs on command.
  Assumes commands change at the falling edge; applied one cycle later.
*/
`timescale 1ns/1ps
module tcc_pin_model (
  input wire logic clk,
  input wire logic [4:0] flip_a,
  input wire logic [4:0] flip_b,
  output logic [4:0] pin_a,
  output logic [4:0] pin_b
);
  // pins start low
  initial begin
    pin_a = 5'h00;
    pin_b = 5'h00;
  end
  // commanded pins toggle on the falling edge
  always @(negedge clk) begin
    pin_a <= pin_a ^ flip_a;
    pin_b <= pin_b ^ flip_b;
  end
endmodule // tcc_pin_model

// ### test/tb_top.sv
/*
  Self-checking bench for tcc_top with the pin model.
  Assumes inputs change at the falling edge of a 100 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk, rstn, stb, we, re, phs, chi, clo;
  logic [4:0] addr, up, dn, fa, fb, pa, pb;
  logic [4:0] ao, aoe, bo, boe, ca, cb, wi, ia, ib;
  logic [7:0] wd, rd_q, ncap;
  logic [3:0] dma;
  logic [4:0][15:0] cnt, ga, gb;
  int n_fail, cmp_count;
  logic [23:0] rows [9] = '{24'h040088, 24'h0477FF, 24'h10129A,
    24'h0C028A, 24'h0607FF, 24'h0600F8, 24'h05FFF8, 24'h1C5A00, 24'h035A00};

  tcc_top dut_u (.CLK(clk), .RSTN(rstn), .STANDBY(stb), .CPU_ADDR(addr),
    .CPU_WE(we), .CPU_RE(re), .CPU_WDATA(wd), .CPU_RDATA(rd_q),
    .CHANNEL_COUNTER(cnt), .GENERAL_REG_A(ga), .GENERAL_REG_B(gb),
    .COUNT_UP_TICK(up), .COUNT_DOWN_TICK(dn), .PHASE_COUNT_SELECT(phs),
    .COMBO_MODE_HI(chi), .COMBO_MODE_LO(clo), .DMA_START_A(dma),
    .CHANNEL_PIN_A_IN(pa), .CHANNEL_PIN_A_OUT(ao), .CHANNEL_PIN_A_OE(aoe),
    .CHANNEL_PIN_B_IN(pb), .CHANNEL_PIN_B_OUT(bo), .CHANNEL_PIN_B_OE(boe),
    .CAPTURE_A(ca), .CAPTURE_B(cb), .WRAP_IRQ(wi),
    .MATCH_CAPTURE_IRQ_A(ia), .MATCH_CAPTURE_IRQ_B(ib));
  tcc_pin_model pm_u (.clk(clk), .flip_a(fa), .flip_b(fb), .pin_a(pa),
    .pin_b(pb));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count capture pulses on channel 1 b
  always @(posedge clk) begin
    if (cb[1]) ncap <= ncap + 8'h01;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    cmp(rd_q, e);
  endtask
  // one cycle of counter equal to general register a
  task automatic hit(input int c);
    @(negedge clk);
    cnt[c] = 16'h0010;
    @(negedge clk);
    cnt[c] = 16'h0000;
    @(negedge clk);
  endtask
  // one edge on channel 1 pin b
  task automatic tgl;
    @(negedge clk) fb <= 5'h02;
    @(negedge clk) fb <= 5'h00;
    @(negedge clk);
  endtask
  task automatic test_done;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #100000;
    n_fail++;
    test_done;
  end

  initial begin
    {rstn, stb, we, re, phs, chi, clo} = 7'h00;
    {addr, up, dn, fa, fb} = 25'h0;
    {wd, ncap, dma} = 20'h0;
    cnt = '0;
    ga = {5{16'h0010}};
    gb = {5{16'h0020}};
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    cmp({3'h0, ao | bo}, 8'h00);
    for (int c = 0; c < 5; c++) begin
      rd(5'(c * 4), 8'h88);
      rd(5'(c * 4 + 1), 8'hF8);
      rd(5'(c * 4 + 2), 8'hF8);
    end
    foreach (rows[i]) begin
      wr(rows[i][20:16], rows[i][15:8]);
      rd(rows[i][20:16], rows[i][7:0]);
    end
    // compare drive one, then flag clearing
    wr(5'h00, 8'h02);
    hit(0);
    cmp({7'h0, ao[0]}, 8'h01);
    rd(5'h01, 8'hF9);
    wr(5'h01, 8'hFF);
    rd(5'h01, 8'hF9);
    wr(5'h01, 8'h00);
    rd(5'h01, 8'hF8);
    hit(0);
    wr(5'h01, 8'h00);
    rd(5'h01, 8'hF9);
    @(negedge clk) dma = 4'h1;
    @(negedge clk) dma = 4'h0;
    rd(5'h01, 8'hF8);
    // toggle, and toggle read as drive one on channel 2
    wr(5'h00, 8'h03);
    hit(0);
    cmp({7'h0, ao[0]}, 8'h00);
    wr(5'h08, 8'h03);
    hit(2);
    hit(2);
    cmp({7'h0, ao[2]}, 8'h01);
    // enables gate flags, overflow sets wrap flag
    wr(5'h02, 8'h04);
    hit(0);
    cmp({7'h0, ia[0]}, 8'h00);
    @(negedge clk) cnt[0] = 16'hFFFF;
    up = 5'h01;
    @(negedge clk) cnt[0] = 16'h0000;
    up = 5'h00;
    cmp({3'h0, wi}, 8'h01);
    rd(5'h01, 8'hFD);
    wr(5'h02, 8'h01);
    cmp({7'h0, ia[0]}, 8'h01);
    // capture codes, one rising then one falling edge each
    for (int c = 4; c < 8; c++) begin
      wr(5'h04, 8'(c << 4));
      ncap = 8'h00;
      tgl;
      tgl;
      cmp(ncap, 8'(c < 6 ? 1 : 2));
    end
    rd(5'h05, 8'hFA);
    wr(5'h06, 8'h02);
    cmp({7'h0, ib[1]}, 8'h01);
    // underflow counts only in phase counting channel 2
    phs = 1'b1;
    @(negedge clk) dn = 5'h06;
    @(negedge clk) dn = 5'h00;
    rd(5'h05, 8'hFA);
    rd(5'h09, 8'hFD);
    // three-phase mode ignores channel 3 and 4 selection
    chi = 1'b1;
    repeat (3) @(negedge clk);
    cmp({6'h0, aoe[4:3]}, 8'h00);
    // down ticks at zero: complementary counts, reset-synchronized not
    dn = 5'h08;
    @(negedge clk) clo = 1'b1;
    dn = 5'h10;
    @(negedge clk) dn = 5'h00;
    {chi, clo} = 2'h0;
    rd(5'h0D, 8'hFC);
    rd(5'h11, 8'hF8);
    cmp({3'h0, boe}, 8'h10);
    // rising edge on channel 3 pin a captures into register a
    wr(5'h0C, 8'h04);
    @(negedge clk) fa <= 5'h08;
    @(negedge clk) fa <= 5'h00;
    @(negedge clk);
    rd(5'h0D, 8'hFD);
    // standby restores io select
    wr(5'h00, 8'h12);
    @(negedge clk) stb = 1'b1;
    @(negedge clk) stb = 1'b0;
    rd(5'h00, 8'h88);
    rd(5'h01, 8'hF8);
    rd(5'h02, 8'hF8);
    test_done;
  end
endmodule // tb_top
